// >>> hw/sllc_pkg.sv
// shared constants for the serial link layer control block
package sllc_pkg;
  // ****************************************
  // register map (printed offsets are word indices)
  // ****************************************
  localparam logic [11:0] LINK_CTRL1_IDX  = 12'h571;
  localparam logic [11:0] LINK_SYNC_IDX   = 12'h572;
  localparam logic [11:0] LINK_STATUS_IDX = 12'h57F;
  localparam logic [13:0] LINK_CTRL1_ADDR  = {LINK_CTRL1_IDX, 2'h0};
  localparam logic [13:0] LINK_SYNC_ADDR   = {LINK_SYNC_IDX, 2'h0};
  localparam logic [13:0] LINK_STATUS_ADDR = {LINK_STATUS_IDX, 2'h0};
  localparam logic [7:0]  LINK_CTRL1_RST   = 8'h14;
  localparam logic [7:0]  LINK_SYNC_RST    = 8'h00;
  localparam logic [7:0]  LINK_SYNC_WMASK  = 8'hF6;

  // ****************************************
  // field positions of the first link control register
  // ****************************************
  localparam int C1_STANDBY_ZSEL = 7;
  localparam int C1_TAIL_PN      = 6;
  localparam int C1_LONG_TPL     = 5;
  localparam int C1_FA_SET       = 4;
  localparam int C1_ILAS_HI      = 3;
  localparam int C1_ILAS_LO      = 2;
  localparam int C1_FA_INS_OFF   = 1;
  localparam int C1_POWER_DOWN   = 0;

  // ****************************************
  // field positions of the sync input control register
  // ****************************************
  localparam int SY_MODE_HI = 7;
  localparam int SY_MODE_LO = 6;
  localparam int SY_INVERT  = 5;
  localparam int SY_SE_TYPE = 4;
  localparam int SY_ENC_BYPASS = 2;
  localparam int SY_ENC_INVERT = 1;

  // ****************************************
  // encodings and timing
  // ****************************************
  localparam logic [1:0] ILAS_OFF    = 2'h0;
  localparam logic [1:0] ILAS_ONCE   = 2'h1;
  localparam logic [1:0] ILAS_REPEAT = 2'h3;
  localparam logic [1:0] SYNC_NORMAL = 2'h0;
  localparam logic [1:0] SYNC_FCGS   = 2'h2;
  localparam logic [1:0] SYNC_FDATA  = 2'h3;
  localparam int         ILAS_LEN_DEF = 16;

  typedef enum logic [1:0] {
    SLLC_PWRDN = 2'b00,
    SLLC_CGS   = 2'b01,
    SLLC_ILAS  = 2'b11,
    SLLC_DATA  = 2'b10
  } sllc_state_t;
endpackage

// >>> hw/sllc_sync_cond.sv
// sync request input conditioning: pin type, polarity and override
`timescale 1ns/1ps
`default_nettype none
module sllc_sync_cond
  import sllc_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       ce_in,
  // pins
  input  wire logic       sync_request_positive_pin_in,
  input  wire logic       sync_request_negative_pin_in,
  // controls
  input  wire logic [1:0] sync_mode_in,
  input  wire logic       sync_invert_in,
  input  wire logic       sync_se_in,
  // result, high when code group sync is requested
  output logic            sync_req_out
);
  logic level;
  logic sync_req_reg;
  logic sync_req_next;

  // pick pin type, then polarity, then override
  always_comb begin
    level = sync_se_in ? sync_request_positive_pin_in
                       : (sync_request_positive_pin_in & ~sync_request_negative_pin_in);
    level = level ^ sync_invert_in;
    unique case (sync_mode_in)
      SYNC_FCGS:  sync_req_next = 1'b1;
      SYNC_FDATA: sync_req_next = 1'b0;
      default:    sync_req_next = ~level;
    endcase
  end

  // register the request
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync_req_reg <= 1'b1;
    end else if (ce_in) begin
      sync_req_reg <= sync_req_next;
    end
  end

  assign sync_req_out = sync_req_reg;
endmodule
`default_nettype wire

// >>> hw/sllc_top.sv
// link layer control: register slave and link sequencing
// Functional notes
// - long transport test bit replaces samples with test sequence on all lanes.
// - alignment set bit set uses K28.3 and K28.7, clear only K28.7.
// - alignment sequence mode 00 off, 01 once, 11 repeated forever.
// - frame alignment characters inserted unless insertion-off bit set (debug).
// - with power bit clear link runs; code group sync follows request.
// - power bit set holds link in reset with clock gated off.
// - sync mode 00 follows input, 10 forces sync, 11 forces data.
// - sync polarity bit inverts received request level.
// - sync type bit selects differential pair or positive pin only.
// - in standby send zero samples, or sync characters when select set.
`timescale 1ns/1ps
`default_nettype none
module sllc_top
  import sllc_pkg::*;
#(
  parameter int ILAS_LEN = ILAS_LEN_DEF
)
(
  // clock, reset, enable
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ce_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // sync request pins and chip standby
  input  wire logic        sync_request_positive_pin_in,
  input  wire logic        sync_request_negative_pin_in,
  input  wire logic        standby_in,
  // link controls
  output logic             link_rst_out,
  output logic             link_clk_en_out,
  output logic             send_cgs_out,
  output logic             send_ilas_out,
  output logic             send_zeros_out,
  output logic             tpl_test_out,
  output logic             frame_align_char_insert_out,
  output logic             fa_use_k28_3_out,
  output logic             tail_pn_out,
  output logic             enc_bypass_out,
  output logic             enc_invert_out
);
  // ****************************************
  // bus slave
  // ****************************************
  logic [7:0]  ctrl1_reg;
  logic [7:0]  ctrl1_next;
  logic [7:0]  syncc_reg;
  logic [7:0]  syncc_next;
  logic        wr_pend_reg;
  logic        wr_pend_next;
  logic [13:0] wr_addr_reg;
  logic [13:0] wr_addr_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic        addr_ok;
  logic [7:0]  status_val;
  logic        sync_req;
  sllc_state_t state_reg;
  sllc_state_t state_next;

  function automatic logic [7:0] read_mux(input logic [13:0] a, input logic [7:0] c1,
                                          input logic [7:0] sy, input logic [7:0] st);
    if (a == LINK_CTRL1_ADDR) begin
      read_mux = c1;
    end else if (a == LINK_SYNC_ADDR) begin
      read_mux = sy;
    end else if (a == LINK_STATUS_ADDR) begin
      read_mux = st;
    end else begin
      read_mux = 8'h00;
    end
  endfunction

  assign addr_ok    = (haddr_in[31:14] == 18'h00000);
  assign status_val = {5'h00, sync_req, state_reg};

  // address phase capture, write in data phase, read data prepared early
  always_comb begin
    wr_pend_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    hrdata_next  = hrdata_reg;
    ctrl1_next   = ctrl1_reg;
    syncc_next   = syncc_reg;
    if (wr_pend_reg) begin
      if (wr_addr_reg == LINK_CTRL1_ADDR) begin
        ctrl1_next = hwdata_in[7:0];
      end else if (wr_addr_reg == LINK_SYNC_ADDR) begin
        syncc_next = hwdata_in[7:0] & LINK_SYNC_WMASK;
      end
    end
    if (hsel_in && htrans_in[1] && hready_in) begin
      wr_pend_next = hwrite_in & addr_ok;
      wr_addr_next = haddr_in[13:0];
      hrdata_next  = 32'h00000000;
      if (!hwrite_in && addr_ok) begin
        hrdata_next = {24'h000000, read_mux(haddr_in[13:0], ctrl1_next, syncc_next, status_val)};
      end
    end
  end

  // bus registers
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl1_reg     <= LINK_CTRL1_RST;
      syncc_reg     <= LINK_SYNC_RST;
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= 14'h0000;
      hrdata_reg    <= 32'h00000000;
    end else if (ce_in) begin
      ctrl1_reg     <= ctrl1_next;
      syncc_reg     <= syncc_next;
      wr_pend_reg   <= wr_pend_next;
      wr_addr_reg   <= wr_addr_next;
      hrdata_reg    <= hrdata_next;
    end
  end

  assign hrdata_out    = hrdata_reg;
  assign hreadyout_out = 1'b1;   // zero wait states, no stall source
  assign hresp_out     = 1'b0;   // always okay

  // ****************************************
  // sync request conditioning
  // ****************************************
  sllc_sync_cond u_sync (
    .ref_clk_in                   (ref_clk_in),
    .sys_rst_in                   (sys_rst_in),
    .ce_in                        (ce_in),
    .sync_request_positive_pin_in (sync_request_positive_pin_in),
    .sync_request_negative_pin_in (sync_request_negative_pin_in),
    .sync_mode_in                 (syncc_reg[SY_MODE_HI:SY_MODE_LO]),
    .sync_invert_in               (syncc_reg[SY_INVERT]),
    .sync_se_in                   (syncc_reg[SY_SE_TYPE]),
    .sync_req_out                 (sync_req)
  );

  // ****************************************
  // link sequencer
  // ****************************************
  logic [1:0]  ilas_mode;
  logic [15:0] ilas_cnt_reg;
  logic [15:0] ilas_cnt_next;
  logic [10:0] out_reg;
  logic [10:0] out_next;

  assign ilas_mode = ctrl1_reg[C1_ILAS_HI:C1_ILAS_LO];

  // next link state
  always_comb begin
    state_next    = state_reg;
    ilas_cnt_next = 16'h0000;
    if (ctrl1_reg[C1_POWER_DOWN]) begin
      state_next = SLLC_PWRDN;
    end else if (sync_req) begin
      state_next = SLLC_CGS;
    end else begin
      unique case (state_reg)
        SLLC_PWRDN: state_next = SLLC_CGS;
        SLLC_CGS: begin
          state_next = (ilas_mode == ILAS_OFF) ? SLLC_DATA : SLLC_ILAS;
        end
        SLLC_ILAS: begin
          ilas_cnt_next = ilas_cnt_reg + 16'h0001;
          if (ilas_mode != ILAS_REPEAT && ilas_cnt_reg == 16'(ILAS_LEN - 1)) begin
            state_next    = SLLC_DATA;
            ilas_cnt_next = 16'h0000;
          end else if (ilas_cnt_reg == 16'(ILAS_LEN - 1)) begin
            ilas_cnt_next = 16'h0000;
          end
        end
        SLLC_DATA: state_next = SLLC_DATA;
      endcase
    end
  end

  // output controls derived from next state and settings
  always_comb begin
    out_next = 11'h000;
    out_next[10] = (state_next == SLLC_PWRDN);
    out_next[9]  = (state_next != SLLC_PWRDN);
    out_next[8]  = (state_next == SLLC_CGS);
    out_next[7]  = (state_next == SLLC_ILAS);
    out_next[5]  = (state_next == SLLC_DATA) & ctrl1_next[C1_LONG_TPL];
    out_next[4]  = ~ctrl1_next[C1_FA_INS_OFF];
    out_next[3]  = ctrl1_next[C1_FA_SET];
    out_next[2]  = ctrl1_next[C1_TAIL_PN];
    out_next[1]  = syncc_next[SY_ENC_BYPASS];
    out_next[0]  = syncc_next[SY_ENC_INVERT];
    if (standby_in && state_next != SLLC_PWRDN) begin
      out_next[8] = ctrl1_next[C1_STANDBY_ZSEL];
      out_next[6] = ~ctrl1_next[C1_STANDBY_ZSEL];
      out_next[7] = 1'b0;
      out_next[5] = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg    <= SLLC_PWRDN;
      ilas_cnt_reg <= 16'h0000;
      out_reg      <= 11'h418;   // link in reset, insertion on, both alignment chars, tail pn off
    end else if (ce_in) begin
      state_reg    <= state_next;
      ilas_cnt_reg <= ilas_cnt_next;
      out_reg      <= out_next;
    end
  end

  assign link_rst_out                = out_reg[10];
  assign link_clk_en_out             = out_reg[9];
  assign send_cgs_out                = out_reg[8];
  assign send_ilas_out               = out_reg[7];
  assign send_zeros_out              = out_reg[6];
  assign tpl_test_out                = out_reg[5];
  assign frame_align_char_insert_out = out_reg[4];
  assign fa_use_k28_3_out            = out_reg[3];
  assign tail_pn_out                 = out_reg[2];
  assign enc_bypass_out              = out_reg[1];
  assign enc_invert_out              = out_reg[0];
endmodule
`default_nettype wire

// >>> verif/sllc_rx_model.sv
// far-end receiver model driving the sync request pins
`timescale 1ns/1ps
`default_nettype none
module sllc_rx_model #(
  parameter int LOCK = 8
)
(
  // clock, reset, commands
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic resync_in,
  input  wire logic neg_stuck_in,
  // sync request pins, request is a low differential level
  output logic      pos_out,
  output logic      neg_out
);
  logic [3:0] cnt_reg;
  // hold the request until character lock is reached on all lanes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= 4'(LOCK);
    end else if (resync_in) begin
      cnt_reg <= 4'(LOCK);
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
  // stuck negative leg lets the single-ended pick be told apart
  assign pos_out = (cnt_reg == 4'h0);
  assign neg_out = (cnt_reg != 4'h0) | neg_stuck_in;
endmodule
`default_nettype wire

// >>> verif/sllc_chk.sv
// assertion checker for the link layer control block
`timescale 1ns/1ps
`default_nettype none
module sllc_chk (
  input wire logic       ref_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic       hwrite_in,
  input wire logic       hready_in,
  input wire logic       link_rst_out,
  input wire logic       link_clk_en_out,
  input wire logic       send_cgs_out,
  input wire logic       send_ilas_out,
  input wire logic       send_zeros_out,
  input wire logic       tpl_test_out,
  input wire logic       frame_align_char_insert_out,
  input wire logic       fa_use_k28_3_out
);
  // ****************************************
  // link output relations
  // ****************************************
  logic wr_taken;
  assign wr_taken = hsel_in & htrans_in[1] & hwrite_in & hready_in;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_pwr_off;
    link_rst_out |-> !(link_clk_en_out | send_cgs_out | send_ilas_out | tpl_test_out | send_zeros_out);
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("link active while powered down");
  property p_pwr_on;
    !link_rst_out |-> link_clk_en_out;
  endproperty
  a_pwr_on: assert property (p_pwr_on) else $error("link clock stopped while enabled");
  property p_excl;
    !(send_cgs_out && send_ilas_out);
  endproperty
  a_excl: assert property (p_excl) else $error("sync and alignment sent together");
  property p_tpl;
    tpl_test_out |-> !(send_cgs_out | send_ilas_out | send_zeros_out);
  endproperty
  a_tpl: assert property (p_tpl) else $error("test samples outside data state");
  property p_order;
    $rose(send_ilas_out) |-> $past(send_cgs_out);
  endproperty
  a_order: assert property (p_order) else $error("alignment not preceded by sync");
  property p_wake;
    $fell(link_rst_out) |-> !send_ilas_out && !tpl_test_out;
  endproperty
  a_wake: assert property (p_wake) else $error("link woke outside sync state");
  property p_k28;
    $changed(fa_use_k28_3_out) |-> $past(wr_taken, 2);
  endproperty
  a_k28: assert property (p_k28) else $error("alignment set changed without write");
  property p_frame_align_char_insert;
    $changed(frame_align_char_insert_out) |-> $past(wr_taken, 2);
  endproperty
  a_frame_align_char_insert: assert property (p_frame_align_char_insert) else $error("insertion changed without write");
  property p_zero;
    send_zeros_out |-> !send_ilas_out && !tpl_test_out;
  endproperty
  a_zero: assert property (p_zero) else $error("zeros mixed with other data");
  c_ilas: cover property ($rose(send_ilas_out));
  c_tpl: cover property ($rose(tpl_test_out));
  c_pwr: cover property ($rose(link_rst_out));
endmodule
bind sllc_top sllc_chk i_chk (.*);
`default_nettype wire

// >>> verif/sllc_tb_top.sv
// self-checking testbench for the link layer control block
`timescale 1ns/1ps
`default_nettype none
module sllc_tb_top;
  import sllc_pkg::*;
  localparam logic [31:0] A1 = {18'h0, LINK_CTRL1_ADDR};
  localparam logic [31:0] AS = {18'h0, LINK_SYNC_ADDR};
  logic        ref_clk_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
  logic        standby_in = 1'b0, rs = 1'b0, stuck = 1'b0, rd_ph = 1'b0, hready_in, hreadyout_out, hresp_out;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, v;
  logic [1:0]  htrans_in = 2'h0;
  logic [2:0]  hsize_in = 3'h2;
  logic        sync_request_positive_pin_in, sync_request_negative_pin_in, link_rst_out, link_clk_en_out;
  logic        send_cgs_out, send_ilas_out, send_zeros_out, tpl_test_out, frame_align_char_insert_out;
  logic        fa_use_k28_3_out, tail_pn_out, enc_bypass_out, enc_invert_out;
  logic [31:0] exp_q[$];
  logic [8:0]  tbl[6] = '{9'h101, 9'h000, 9'h041, 9'h003, 9'h022, 9'h182};
  int          num_errors = 0, checked = 0, n;
  assign hready_in = hreadyout_out;
  sllc_top #(.ILAS_LEN(2)) i_dut (.*);
  sllc_rx_model #(.LOCK(8)) i_rx (.clk_in(ref_clk_in), .rst_in(sys_rst_in), .resync_in(rs), .neg_stuck_in(stuck),
    .pos_out(sync_request_positive_pin_in), .neg_out(sync_request_negative_pin_in));
  always #10 ref_clk_in = ~ref_clk_in;
  // ****************************************
  // tasks
  // ****************************************
  task automatic cmp(input logic [31:0] act, input logic [31:0] exp);
    checked++;
    if (act !== exp) begin
      num_errors++;
      $display("Error at %0t: read %h expected %h", $time, act, exp);
    end
  endtask
  task automatic cb(input logic act, input logic exp);
    checked++;
    if (act !== exp) begin
      num_errors++;
      $display("Error at %0t: output %b expected %b", $time, act, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= w;
    do @(posedge ref_clk_in); while (hready_in !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= {24'h0, d};
    if (!w) exp_q.push_back({24'h0, d});
    do @(posedge ref_clk_in); while (hready_in !== 1'b1);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // read data monitor: oldest expected value against the data phase
  always @(posedge ref_clk_in) begin
    if (rd_ph) cmp(hrdata_out, exp_q.pop_front());
    rd_ph <= hsel_in && htrans_in[1] && !hwrite_in && hready_in;
  end
  // watchdog
  initial begin
    tick(5000);
    num_errors++;
    wrap_up();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hd13c));
    tick(6);
    cb(link_rst_out, 1'b1);
    cb(fa_use_k28_3_out, 1'b1);
    cb(tail_pn_out, 1'b0);
    sys_rst_in <= 1'b0;
    ahb(1'b0, A1, LINK_CTRL1_RST);
    ahb(1'b0, AS, 8'h00);
    ahb(1'b0, 32'h0000_0100, 8'h00);
    v = $urandom;
    ahb(1'b1, AS, v[7:0]);
    ahb(1'b0, AS, v[7:0] & LINK_SYNC_WMASK);
    cb(enc_bypass_out, v[2]);
    cb(enc_invert_out, v[1]);
    ahb(1'b1, AS, 8'h00);
    $display("registers done");
    ahb(1'b1, A1, 8'h74);
    tick(3);
    cb(tpl_test_out, 1'b1);
    cb(tail_pn_out, 1'b1);
    ahb(1'b1, A1, 8'h04);
    tick(3);
    cb(tpl_test_out, 1'b0);
    cb(fa_use_k28_3_out, 1'b0);
    cb(frame_align_char_insert_out, 1'b1);
    ahb(1'b1, A1, 8'h06);
    tick(3);
    cb(frame_align_char_insert_out, 1'b0);
    $display("control bits done");
    for (int m = 0; m < 4; m++) begin
      if (m != 2) begin
        ahb(1'b1, A1, 8'h10 | {4'h0, m[1:0], 2'h0});
        rs <= 1'b1;
        tick(1);
        rs <= 1'b0;
        n = 0;
        tick(3);
        cb(send_cgs_out, 1'b1);
        repeat (24) begin
          tick(1);
          n += int'(send_ilas_out === 1'b1);
        end
        cb(send_ilas_out, m == 3);
        if (m != 3) cb(n == (m == 1 ? 2 : 0), 1'b1);
      end
    end
    ahb(1'b1, A1, 8'h14);
    $display("alignment modes done");
    foreach (tbl[i]) begin
      stuck <= tbl[i][1];
      ahb(1'b1, AS, tbl[i][8:2] << 1);
      tick(8);
      cb(send_cgs_out, tbl[i][0]);
    end
    stuck <= 1'b0;
    ahb(1'b1, AS, 8'h00);
    $display("sync modes done");
    standby_in <= 1'b1;
    tick(3);
    cb(send_zeros_out, 1'b1);
    ahb(1'b1, A1, 8'h94);
    tick(3);
    cb(send_cgs_out, 1'b1);
    standby_in <= 1'b0;
    ahb(1'b1, A1, 8'h14);
    $display("standby done");
    ahb(1'b1, A1, 8'h15);
    tick(3);
    cb(link_rst_out, 1'b1);
    cb(link_clk_en_out, 1'b0);
    ahb(1'b1, A1, 8'h14);
    tick(3);
    cb(link_clk_en_out, 1'b1);
    $display("power done");
    wrap_up();
  end
endmodule
`default_nettype wire
